// ==== verilog/ifp_consts.svh ====
// Overview of operation
// - Flag register two holds the listed source bits
// - Flags set by source, software read/write, reset zero
// - Unimplemented bits ignore writes, read zero
// - Priority field value is level; zero disables
// - Priority fields reset to binary 100
// - First priority register holds timer4/compare/DMA2 fields
// - Second priority register holds CAN/serial2 fields
// - Manual trigger bit forces exactly one transfer
// - Trigger clear: selected request starts each transfer
// - Manual bit cleared only by hardware on completion
// - Seven-bit field selects one of 128 requests
// - Request select register resets to zero
`ifndef IFP_CONSTS_SVH
`define IFP_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IFP_AW            4
`define IFP_A_FLAG        4'h0
`define IFP_A_PRIO1       4'h1
`define IFP_A_PRIO2       4'h2
`define IFP_A_DREQ        4'h3
`define IFP_A_IST         4'h4
`define IFP_A_IMSK        4'h5

// ----------------------------------------
// Field layouts and reset values
// ----------------------------------------
`define IFP_FLAG_MASK     16'hDFFF
`define IFP_FLAG_RST      16'h0000
`define IFP_PRIO_MASK     16'h7777
`define IFP_PRIO_RST      16'h4444
`define IFP_DREQ_MASK     16'h807F
`define IFP_DREQ_RST      16'h0000
`define IFP_FORCE_BIT     15
`define IFP_SEL_W         7
`define IFP_FLD_STRIDE    4
`define IFP_NSRC          8
`define IFP_SRC_W         3
`define IFP_EV_W          2
`define IFP_EV_FDONE      0
`define IFP_EV_FLAG       1
`define IFP_EV_MASK       16'h0003

`endif

// ==== verilog/ifp_pkg.sv ====
package ifp_pkg;

  typedef logic [2:0] ifp_prio_t;

  typedef enum logic [1:0] {
    IFP_IDLE  = 2'b00,
    IFP_ISSUE = 2'b01,
    IFP_WAIT  = 2'b10
  } ifp_fstate_t;

endpackage : ifp_pkg

// ==== verilog/ifp_dma_req_sel.sv ====
`timescale 1ns/1ps
`include "ifp_consts.svh"

module ifp_dma_req_sel
  import ifp_pkg::*;
#(
  parameter int NREQ = 128
)
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  wr_en,
  input  wire logic [15:0]           wdata,
  input  wire logic [NREQ-1:0]       request_number,
  input  wire logic                  dma_done,
  output logic                       force_o,
  output logic [`IFP_SEL_W-1:0]      request_source_select,
  output logic                       channel_trigger_request,
  output logic                       force_done
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ifp_fstate_t             st_q;
  ifp_fstate_t             st_d;
  logic                    force_set;
  logic                    auto_hit;
  logic                    start_d;

  assign force_set = wr_en & wdata[`IFP_FORCE_BIT];
  // Peripheral requests are held off while a forced transfer is pending
  assign auto_hit  = (st_q == IFP_IDLE) & ~force_set & request_number[request_source_select];
  assign start_d   = (st_q == IFP_ISSUE) | auto_hit;

  always_comb
  begin
    case (st_q)
      IFP_IDLE:  st_d = force_set ? IFP_ISSUE : IFP_IDLE;
      IFP_ISSUE: st_d = IFP_WAIT;
      IFP_WAIT:  st_d = dma_done ? IFP_IDLE : IFP_WAIT;
      default:   st_d = IFP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q                    <= IFP_IDLE;
      request_source_select   <= '0;
      force_o                 <= 1'b0;
      channel_trigger_request <= 1'b0;
      force_done              <= 1'b0;
    end
    else
    begin
      st_q                    <= st_d;
      // Writing zero to the manual bit has no effect
      force_o                 <= (st_d != IFP_IDLE);
      channel_trigger_request <= start_d;
      force_done              <= (st_q == IFP_WAIT) & dma_done;
      if (wr_en)
        request_source_select <= wdata[`IFP_SEL_W-1:0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_force_req;
    (st_q == IFP_IDLE) && force_set;
  endsequence

  sequence s_one_pulse;
    ##2 channel_trigger_request ##1 !channel_trigger_request;
  endsequence

  AST_FORCE_ONE: assert property (s_force_req |-> s_one_pulse)
    else $error("forced transfer not issued as single pulse");
  AST_FORCE_HOLD: assert property (force_o && (st_q == IFP_WAIT) && !dma_done |=> force_o)
    else $error("manual bit dropped before completion");
  AST_FORCE_CLR: assert property ((st_q == IFP_WAIT) && dma_done |=> !force_o && force_done)
    else $error("manual bit not cleared on completion");
  AST_AUTO_START: assert property ((st_q == IFP_IDLE) && !force_set
                                   && request_number[request_source_select] |=> channel_trigger_request)
    else $error("selected request did not start transfer");

endmodule : ifp_dma_req_sel

// ==== verilog/ifp_top.sv ====
`timescale 1ns/1ps
`include "ifp_consts.svh"

module ifp_top
  import ifp_pkg::*;
#(
  parameter int NREQ = 128
)
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [`IFP_AW-1:0]    addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [15:0]           rdata,
  input  wire logic [15:0]           src_evt,
  input  wire logic [3:0]            ext_pend,
  input  wire logic [NREQ-1:0]       request_number,
  input  wire logic                  dma_done,
  output logic                       channel_trigger_request,
  output logic                       cpu_req,
  output logic      [2:0]            cpu_level,
  output logic      [`IFP_SRC_W-1:0] cpu_src,
  output logic                       irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic ifp_prio_t prio_of(input logic [15:0] r, input int unsigned k);
    prio_of = r[k*`IFP_FLD_STRIDE +: 3];
  endfunction : prio_of

  function automatic logic hit(input logic [`IFP_AW-1:0] a, input logic [`IFP_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic                    wr_flag;
  logic                    wr_prio1;
  logic                    wr_prio2;
  logic                    wr_dreq;
  logic                    wr_ist;
  logic                    wr_imsk;

  assign wr_flag  = wr & hit(addr, `IFP_A_FLAG);
  assign wr_prio1 = wr & hit(addr, `IFP_A_PRIO1);
  assign wr_prio2 = wr & hit(addr, `IFP_A_PRIO2);
  assign wr_dreq  = wr & hit(addr, `IFP_A_DREQ);
  assign wr_ist   = wr & hit(addr, `IFP_A_IST);
  assign wr_imsk  = wr & hit(addr, `IFP_A_IMSK);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0]             flag_q;
  logic [15:0]             flag_d;
  logic [15:0]             prio1_q;
  logic [15:0]             prio2_q;
  logic [`IFP_EV_W-1:0]    ist_q;
  logic [`IFP_EV_W-1:0]    ist_d;
  logic [`IFP_EV_W-1:0]    imsk_q;
  logic [`IFP_EV_W-1:0]    ev;
  logic [15:0]             flag_new;
  logic                    force_bit;
  logic [`IFP_SEL_W-1:0]   sel;
  logic                    force_done;

  // A source pulse in the same cycle as a software write wins
  assign flag_new = src_evt & `IFP_FLAG_MASK & ~flag_q;
  assign flag_d   = ((wr_flag ? wdata : flag_q) | src_evt) & `IFP_FLAG_MASK;

  assign ev[`IFP_EV_FDONE] = force_done;
  assign ev[`IFP_EV_FLAG]  = |flag_new;
  assign ist_d = (wr_ist ? (ist_q & ~wdata[`IFP_EV_W-1:0]) : ist_q) | ev;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flag_q  <= `IFP_FLAG_RST;
      prio1_q <= `IFP_PRIO_RST;
      prio2_q <= `IFP_PRIO_RST;
      ist_q   <= '0;
      imsk_q  <= '0;
    end
    else
    begin
      flag_q <= flag_d;
      ist_q  <= ist_d;
      if (wr_prio1)
        prio1_q <= wdata & `IFP_PRIO_MASK;
      if (wr_prio2)
        prio2_q <= wdata & `IFP_PRIO_MASK;
      if (wr_imsk)
        imsk_q <= wdata[`IFP_EV_W-1:0];
    end
  end

  // ----------------------------------------
  // DMA request selector
  // ----------------------------------------
  ifp_dma_req_sel #(
    .NREQ                    (NREQ)
  ) u_dreq (
    .clk                     (clk),
    .rstn                    (rstn),
    .wr_en                   (wr_dreq),
    .wdata                   (wdata),
    .request_number          (request_number),
    .dma_done                (dma_done),
    .force_o                 (force_bit),
    .request_source_select   (sel),
    .channel_trigger_request (channel_trigger_request),
    .force_done              (force_done)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [15:0]             dreq_rd;
  logic [15:0]             rd_mux;

  assign dreq_rd = {force_bit, 8'h00, sel};

  always_comb
  begin
    case (addr)
      `IFP_A_FLAG:  rd_mux = flag_q;
      `IFP_A_PRIO1: rd_mux = prio1_q;
      `IFP_A_PRIO2: rd_mux = prio2_q;
      `IFP_A_DREQ:  rd_mux = dreq_rd;
      `IFP_A_IST:   rd_mux = {14'h0000, ist_q};
      `IFP_A_IMSK:  rd_mux = {14'h0000, imsk_q};
      default:      rd_mux = 16'h0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 16'h0000;
    else
      rdata <= rd ? rd_mux : 16'h0000;
  end

  // ----------------------------------------
  // Priority resolution
  // ----------------------------------------
  // Candidates 0..3 pair second-register fields with flag bits 3..0;
  // candidates 4..7 pair first-register fields with pending bits kept
  // in another flag bank, which arrive on ext_pend.
  logic [`IFP_NSRC-1:0]    pend;
  ifp_prio_t               lvl [`IFP_NSRC];
  logic [`IFP_NSRC-1:0]    elig;
  ifp_prio_t               best_lvl;
  logic [`IFP_SRC_W-1:0]   best_src;

  // Pending bank order is reversed against candidate order on both halves
  assign pend = {ext_pend[0], ext_pend[1], ext_pend[2], ext_pend[3],
                 flag_q[0], flag_q[1], flag_q[2], flag_q[3]};

  always_comb
  begin
    for (int i = 0; i < `IFP_NSRC / 2; i++)
    begin
      lvl[i]     = prio_of(prio2_q, 3 - i);
      lvl[i + 4] = prio_of(prio1_q, 3 - i);
    end
  end

  always_comb
  begin
    for (int i = 0; i < `IFP_NSRC; i++)
      elig[i] = pend[i] & (lvl[i] != 3'h0);
  end

  // Equal levels resolve toward the lower candidate index
  always_comb
  begin
    best_lvl = 3'h0;
    best_src = '0;
    for (int i = 0; i < `IFP_NSRC; i++)
    begin
      if (elig[i] && (lvl[i] > best_lvl))
      begin
        best_lvl = lvl[i];
        best_src = i[`IFP_SRC_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpu_req   <= 1'b0;
      cpu_level <= 3'h0;
      cpu_src   <= '0;
      irq       <= 1'b0;
    end
    else
    begin
      cpu_req   <= |elig;
      cpu_level <= best_lvl;
      cpu_src   <= best_src;
      irq       <= |(ist_q & imsk_q);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_FLAG_SET: assert property ((src_evt & `IFP_FLAG_MASK) != 16'h0000
                                 |=> (flag_q & $past(src_evt & `IFP_FLAG_MASK))
                                     == $past(src_evt & `IFP_FLAG_MASK))
    else $error("source pulse did not set its flag");
  AST_FLAG_WR: assert property (wr_flag && src_evt == 16'h0000
                                |=> flag_q == ($past(wdata) & `IFP_FLAG_MASK))
    else $error("flag write not stored");
  AST_RSV_ZERO: assert property (flag_q[13] == 1'b0 && (prio1_q & ~`IFP_PRIO_MASK) == 16'h0000
                                 && (prio2_q & ~`IFP_PRIO_MASK) == 16'h0000)
    else $error("unimplemented bit set");
  AST_RD_FLAG: assert property (rd && hit(addr, `IFP_A_FLAG) |=> rdata == $past(flag_q))
    else $error("flag read data wrong");
  AST_RD_DREQ: assert property (rd && hit(addr, `IFP_A_DREQ)
                                |=> (rdata & ~`IFP_DREQ_MASK) == 16'h0000)
    else $error("select register reserved bits not zero");
  AST_NO_ELIG: assert property (elig == '0 |=> !cpu_req)
    else $error("request without eligible source");
  AST_REQ_LVL: assert property (cpu_req |-> cpu_level != 3'h0
                                && cpu_level >= $past(lvl[0] & {3{elig[0]}}))
    else $error("request level not highest");
  AST_IRQ_OUT: assert property ((ist_q & imsk_q) != '0 |=> irq)
    else $error("unmasked status did not raise irq");

endmodule : ifp_top

// ==== dv/ifp_dma_model.sv ====
`timescale 1ns/1ps

module ifp_dma_model
#(
  parameter int DELAY = 20
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic channel_trigger_request,
  output logic      dma_done
);
  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  int cnt_q;

  // Slow on purpose: a new start restarts the wait, like a busy channel
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q    <= 0;
      dma_done <= 1'b0;
    end
    else
    begin
      dma_done <= (cnt_q == 1);
      if (channel_trigger_request)
        cnt_q <= DELAY;
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule : ifp_dma_model

// ==== dv/ifp_bench.sv ====
`timescale 1ns/1ps
`include "ifp_consts.svh"

module interrupt_flags_priority_dma_trigger_bench;
  logic         clk, rstn, wr, rd, dma_done, trig, cpu_req, irq;
  logic [3:0]   addr, ext_pend;
  logic [15:0]  wdata, rdata, src_evt, rv;
  logic [127:0] request_number;
  logic [2:0]   cpu_level, cpu_src;
  int           errors, n_checks, n_trig, n0, i;

  ifp_top #(.NREQ(128)) DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .src_evt(src_evt), .ext_pend(ext_pend), .request_number(request_number),
    .dma_done(dma_done), .channel_trigger_request(trig), .cpu_req(cpu_req), .cpu_level(cpu_level),
    .cpu_src(cpu_src), .irq(irq));

  ifp_dma_model #(.DELAY(20)) engine (.clk(clk), .rstn(rstn), .channel_trigger_request(trig),
    .dma_done(dma_done));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input bit c = 1);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
    if (c)
      check("rdata", rv, e);
  endtask : rd_reg

  // One request line high for one cycle; start is due the next cycle
  task automatic pulse_req(input int n, input logic e);
    @(posedge clk);
    request_number[n] <= 1'b1;
    @(posedge clk);
    request_number <= '0;
    #1;
    check("trigger", {15'h0, trig}, {15'h0, e});
  endtask : pulse_req

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    if (trig === 1'b1)
      n_trig++;

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end

  initial
  begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    src_evt = '0;
    ext_pend = '0;
    request_number = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(`IFP_A_FLAG, 16'h0000);
    rd_reg(`IFP_A_PRIO1, 16'h4444);
    rd_reg(`IFP_A_PRIO2, 16'h4444);
    rd_reg(`IFP_A_DREQ, 16'h0000);
    wr_reg(`IFP_A_FLAG, 16'hFFFF);
    rd_reg(`IFP_A_FLAG, 16'hDFFF);
    wr_reg(`IFP_A_PRIO1, 16'hFFFF);
    rd_reg(`IFP_A_PRIO1, 16'h7777);
    wr_reg(`IFP_A_PRIO2, 16'hFFFF);
    rd_reg(`IFP_A_PRIO2, 16'h7777);
    wr_reg(`IFP_A_DREQ, 16'h7FFF);
    rd_reg(`IFP_A_DREQ, 16'h007F);
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, 16'h0000);
    check("level", {13'h0, cpu_level}, 16'h0007);
    check("src", {13'h0, cpu_src}, 16'h0000);
    wr_reg(`IFP_A_FLAG, 16'h0000);
    wr_reg(`IFP_A_PRIO1, 16'h0000);
    wr_reg(`IFP_A_PRIO2, 16'h0305);
    @(posedge clk);
    src_evt <= 16'h000D;
    @(posedge clk);
    src_evt <= '0;
    rd_reg(`IFP_A_FLAG, 16'h000D);
    check("level", {13'h0, cpu_level}, 16'h0005);
    check("src", {13'h0, cpu_src}, 16'h0003);
    wr_reg(`IFP_A_PRIO2, 16'h0000);
    repeat (2) @(posedge clk);
    check("req", {15'h0, cpu_req}, 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      wr_reg(`IFP_A_PRIO1, 16'(i + 1) << (4 * i));
      ext_pend <= 4'(1 << i);
      repeat (3) @(posedge clk);
      check("level", {13'h0, cpu_level}, 16'(i + 1));
      check("src", {13'h0, cpu_src}, 16'(7 - i));
    end
    ext_pend <= '0;
    wr_reg(`IFP_A_DREQ, 16'h007F);
    pulse_req(127, 1'b1);
    pulse_req(126, 1'b0);
    wr_reg(`IFP_A_DREQ, 16'h0000);
    pulse_req(0, 1'b1);
    repeat (30) @(posedge clk);
    wr_reg(`IFP_A_IST, 16'h0003);
    n0 = n_trig;
    wr_reg(`IFP_A_DREQ, 16'h8005);
    rd_reg(`IFP_A_DREQ, 16'h8005);
    wr_reg(`IFP_A_DREQ, 16'h0005);
    rd_reg(`IFP_A_DREQ, 16'h8005);
    pulse_req(5, 1'b0);
    for (i = 0; i < 50 && rv[15] !== 1'b0; i++)
      rd_reg(`IFP_A_DREQ, 16'h0000, 0);
    check("force", rv, 16'h0005);
    check("starts", 16'(n_trig - n0), 16'h0001);
    rd_reg(`IFP_A_IST, 16'h0001);
    check("irq", {15'h0, irq}, 16'h0000);
    wr_reg(`IFP_A_IMSK, 16'h0001);
    repeat (2) @(posedge clk);
    check("irq", {15'h0, irq}, 16'h0001);
    wr_reg(`IFP_A_IST, 16'h0001);
    @(posedge clk);
    src_evt <= 16'h8000;
    @(posedge clk);
    src_evt <= '0;
    rd_reg(`IFP_A_IST, 16'h0002);
    check("irq", {15'h0, irq}, 16'h0000);
    stop_test();
  end
endmodule : interrupt_flags_priority_dma_trigger_bench
